// file: common/bus_pins_regs.vh
`ifndef BUS_PINS_REGS_VH
`define BUS_PINS_REGS_VH

// Register map (word offsets, one per register, not byte addresses)
`define REG_CTRL        4'h0
`define REG_STATUS      4'h1
`define REG_CYCLE       4'h2
`define REG_ADDR        4'h3
`define REG_WDATA       4'h4
`define REG_RDATA       4'h5
`define REG_DMA         4'h6
// Control register fields
`define CTRL_TOC_LO     0
`define CTRL_TOC_HI     1
`define CTRL_DEST_HI    2
`define CTRL_SRC_HI     3
`define CTRL_CK1_DIS    4
`define CTRL_CLEAR_TO_SEND1_N_EN    5
`define CTRL_DREQ_EDGE0 6
`define CTRL_DREQ_EDGE1 7
// Cycle command encodings (write REG_CYCLE)
`define CYC_FETCH       3'h0
`define CYC_MEM_RD      3'h1
`define CYC_MEM_WR      3'h2
`define CYC_IO_RD       3'h3
`define CYC_IO_WR       3'h4
`define CYC_REFRESH     3'h5
`define CYC_HALT        3'h6
`define CYC_SLEEP       3'h7
`define NMI_VECTOR      20'h00066
`define UNMAPPED_DATA   32'hDEADBEEF
`endif

// file: core/dma_req_sense.v
`timescale 1ns/1ps
// Synchronised DMA request, sensed by level or falling edge
module dma_req_sense (
    // Clock and reset
    input  wire sys_clk,
    input  wire reset_n,
    // Pin and mode
    input  wire req_pin_n,
    input  wire edge_mode,
    input  wire consume,
    // Result
    output wire pending
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    reg edge_r;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r   <= 1'b1;
            s2_r   <= 1'b1;
            s3_r   <= 1'b1;
            edge_r <= 1'b0;
        end else begin
            s1_r <= req_pin_n;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Set wins over consume so no edge is lost
            if (s3_r && !s2_r)
                edge_r <= 1'b1;
            else if (consume)
                edge_r <= 1'b0;
        end
    end
    assign pending = edge_mode ? edge_r : !s2_r;
endmodule

// file: core/bus_pins.v
`timescale 1ns/1ps
`include "bus_pins_regs.vh"
module bus_pins (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        reset_n,
    // Avalon-MM slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Address and data pins
    output wire [19:0] addr_out,
    output wire        addr_oe,
    input  wire [7:0]  data_in,
    output wire [7:0]  data_out,
    output wire        data_oe,
    // Strobes and status
    output wire        memory_strobe_n,
    output wire        io_strobe_n,
    output wire        read_strobe_n,
    output wire        write_strobe_n,
    output wire        ctrl_oe,
    output wire        opcode_cycle_n,
    output wire        refresh_cycle_n,
    output wire        halt_n,
    output wire        cycle_status,
    output wire        system_clock_out,
    // Bus exchange, wait, interrupts
    input  wire        ext_bus_request_n,
    output wire        ext_bus_grant_n,
    input  wire        wait_n,
    input  wire        nmi_n,
    input  wire        irq0_n,
    input  wire        irq1_n,
    input  wire        irq2_n,
    // Peripheral sources for shared pins
    input  wire        timer1_pulse_out,
    input  wire        async_clock0_out,
    input  wire        async_clock0_oe,
    input  wire        async_clock1_out,
    input  wire        async_clock1_oe,
    input  wire        async_tx_clk0,
    input  wire        async_tx_clk1,
    input  wire        async_tx_bit0,
    input  wire        async_tx_bit1,
    // Shared pins
    input  wire        pin_ck0_in,
    output wire        pin_ck0_out,
    output wire        pin_ck0_oe,
    input  wire        pin_ck1_in,
    output wire        pin_ck1_out,
    output wire        pin_ck1_oe,
    input  wire        pin_rxs_clear_to_send1_n,
    input  wire        dma_req1_n,
    output wire        dma_done1_n,
    output wire        async_tx0,
    output wire        async_tx1,
    // To peripherals
    output wire        async_clock0_in,
    output wire        async_clock1_in,
    output wire        sync_serial_rx,
    output wire        clear_to_send1_n
);
    // --------------------------------------------------------------
    // Bus states
    // --------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_T1    = 3'd1;
    localparam [2:0] ST_T2    = 3'd2;
    localparam [2:0] ST_T3    = 3'd3;
    localparam [2:0] ST_FLOAT = 3'd4;
    localparam [2:0] ST_GRANT = 3'd5;
    localparam [2:0] ST_HALT  = 3'd6;

    reg  [2:0]  state_r;
    reg  [7:0]  ctrl_r;
    reg  [2:0]  cyc_r;
    reg  [1:0]  cls_r;
    reg         first_r;
    reg  [19:0] addr_r;
    reg  [7:0]  wdata_r;
    reg  [7:0]  rdata_r;
    reg  [1:0]  dma_last_r;
    reg         ack_r;
    reg         phase_r;
    reg  [2:0]  sync_a_r;
    reg  [2:0]  sync_b_r;
    reg  [4:0]  sync_c_r;
    reg  [4:0]  sync_d_r;
    reg  [3:0]  ck_r;
    reg         tx0_r;
    reg         tx1_r;
    reg  [1:0]  txc_prev_r;
    reg         nmi_prev_r;
    reg         nmi_pend_r;
    reg  [19:0] pc_r;
    reg         busy_r;
    wire        breq = !sync_a_r[1];
    wire        wait_lo = !sync_a_r[2];
    wire        nmi_s = sync_c_r[1];
    wire [1:0]  dreq_pend;
    wire        sel_timer = ctrl_r[`CTRL_TOC_LO] | ctrl_r[`CTRL_TOC_HI];
    wire        sel_dma_req0_n = ctrl_r[`CTRL_DEST_HI] | ctrl_r[`CTRL_SRC_HI];
    wire        wr_cyc = (cyc_r == `CYC_MEM_WR) || (cyc_r == `CYC_IO_WR);
    wire        io_cyc = (cyc_r == `CYC_IO_RD) || (cyc_r == `CYC_IO_WR);
    wire        rd_cyc = (cyc_r == `CYC_FETCH) || (cyc_r == `CYC_MEM_RD)
                         || (cyc_r == `CYC_IO_RD);
    wire        active = (state_r == ST_T1) || (state_r == ST_T2) || (state_r == ST_T3);
    wire        driving = (state_r != ST_FLOAT) && (state_r != ST_GRANT);
    wire        is_dma = (cls_r == 2'd1);
    wire        is_ack0 = (cls_r == 2'd2);
    wire        is_ack12 = (cls_r == 2'd3);
    wire        bus_wr = (avs_address == `REG_ADDR) && avs_write;

    // --------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a_r <= 3'h7;
            sync_b_r <= 3'h7;
            sync_c_r <= 5'h1F;
            sync_d_r <= 5'h1F;
        end else begin
            sync_b_r <= {wait_n, ext_bus_request_n, 1'b1};
            sync_a_r <= sync_b_r;
            sync_d_r <= {irq2_n, irq1_n, irq0_n, nmi_n, 1'b1};
            sync_c_r <= sync_d_r;
        end
    end

    // --------------------------------------------------------------
    // Clock out, divider enable
    // --------------------------------------------------------------
    // half rate clock
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            phase_r <= 1'b0;
        else
            phase_r <= ~phase_r;
    end
    assign system_clock_out = phase_r;
    // Bus steps once per output clock; WAIT sampled mid-period (falling edge)
    wire step = phase_r;

    // --------------------------------------------------------------
    // Bus state machine
    // --------------------------------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= ST_FLOAT;
            cyc_r      <= `CYC_FETCH;
            cls_r      <= 2'd0;
            first_r    <= 1'b1;
            addr_r     <= 20'h00000;
            wdata_r    <= 8'h00;
            rdata_r    <= 8'h00;
            dma_last_r <= 2'b00;
            ack_r      <= 1'b0;
            nmi_prev_r <= 1'b1;
            nmi_pend_r <= 1'b0;
            pc_r       <= 20'h00000;
            busy_r     <= 1'b0;
            ctrl_r     <= 8'h00;
        end else begin
            ack_r      <= 1'b0;
            nmi_prev_r <= nmi_s;
            if (avs_write && avs_address == `REG_CTRL)
                ctrl_r <= avs_writedata[7:0];
            if (nmi_prev_r && !nmi_s)
                nmi_pend_r <= 1'b1;
            else if (avs_read && avs_address == `REG_STATUS)
                nmi_pend_r <= 1'b0;
            if (bus_wr)
                addr_r <= avs_writedata[19:0];
            if (avs_write && avs_address == `REG_WDATA)
                wdata_r <= avs_writedata[7:0];
            if (avs_write && avs_address == `REG_DMA)
                dma_last_r <= avs_writedata[1:0];
            if (avs_write && avs_address == `REG_CYCLE && !busy_r) begin
                cyc_r  <= avs_writedata[2:0];
                cls_r  <= avs_writedata[5:4];
                first_r <= avs_writedata[8];
                busy_r <= 1'b1;
            end
            if (step) begin
                case (state_r)
                ST_IDLE: begin
                    if (breq)
                        state_r <= ST_FLOAT;
                    else if (busy_r && (cyc_r == `CYC_HALT || cyc_r == `CYC_SLEEP))
                        state_r <= ST_HALT;
                    else if (busy_r)
                        state_r <= ST_T1;
                end
                ST_T1: state_r <= ST_T2;
                ST_T2: begin
                    if (!wait_lo)
                        state_r <= ST_T3;
                end
                ST_T3: begin
                    if (rd_cyc)
                        rdata_r <= data_in;
                    if (cyc_r == `CYC_FETCH)
                        pc_r <= addr_r + 20'h00001;
                    busy_r  <= 1'b0;
                    ack_r   <= 1'b1;
                    state_r <= breq ? ST_FLOAT : ST_IDLE;
                end
                ST_FLOAT: state_r <= breq ? ST_GRANT : ST_IDLE;
                ST_GRANT: if (!breq) state_r <= ST_IDLE;
                ST_HALT: begin
                    // grant from halt too; halt is re-entered after release
                    if (breq)
                        state_r <= ST_FLOAT;
                    else if (nmi_pend_r || !sync_c_r[2] || !sync_c_r[3] || !sync_c_r[4]) begin
                        busy_r  <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // Bus pins
    // --------------------------------------------------------------
    // address float
    assign addr_oe  = driving;
    assign data_oe  = driving && active && wr_cyc;
    assign ctrl_oe  = driving;
    assign data_out = wdata_r;
    assign addr_out = {addr_r[19], sel_timer ? timer1_pulse_out : addr_r[18],
                       io_cyc ? 2'b00 : addr_r[17:16],
                       cyc_r == `CYC_REFRESH ? 8'h00 : addr_r[15:8], addr_r[7:0]};
    assign memory_strobe_n = !(active && !io_cyc && !is_ack0 && !is_ack12);
    assign io_strobe_n     = !(active && (io_cyc || is_ack0) && !is_ack12);
    assign read_strobe_n   = !(active && rd_cyc && !is_ack12 && !is_ack0);
    assign write_strobe_n  = !(active && wr_cyc && state_r != ST_T1);
    assign refresh_cycle_n = !(active && cyc_r == `CYC_REFRESH);
    assign opcode_cycle_n  = !((active && (cyc_r == `CYC_FETCH || is_ack0) && !is_dma)
                              || (state_r == ST_HALT && cyc_r == `CYC_HALT));
    assign halt_n          = !(state_r == ST_HALT);
    assign cycle_status    = (state_r == ST_HALT) ? (cyc_r == `CYC_SLEEP)
                             : !(is_dma || (active && cyc_r == `CYC_FETCH && first_r));
    assign ext_bus_grant_n = !(state_r == ST_GRANT);
    assign dma_done1_n = !(is_dma && active && wr_cyc && dma_last_r[1]);
    wire   done0_n     = !(is_dma && active && wr_cyc && dma_last_r[0]);

    // --------------------------------------------------------------
    // Shared pins
    // --------------------------------------------------------------
    // clock 0 or DMA request 0
    assign pin_ck0_out     = async_clock0_out;
    assign pin_ck0_oe      = async_clock0_oe && !sel_dma_req0_n;
    assign async_clock0_in = ck_r[2];
    // clock 1 or transfer end 0
    assign pin_ck1_out     = ctrl_r[`CTRL_CK1_DIS] ? done0_n : async_clock1_out;
    assign pin_ck1_oe      = ctrl_r[`CTRL_CK1_DIS] | async_clock1_oe;
    assign async_clock1_in = ck_r[3];
    assign sync_serial_rx   = ctrl_r[`CTRL_CLEAR_TO_SEND1_N_EN] ? 1'b1 : pin_rxs_clear_to_send1_n;
    assign clear_to_send1_n = ctrl_r[`CTRL_CLEAR_TO_SEND1_N_EN] ? pin_rxs_clear_to_send1_n : 1'b1;
    // Two stages: the clock pins are asynchronous to sys_clk
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            ck_r <= 4'h0;
        else
            ck_r <= {ck_r[1:0], pin_ck1_in, pin_ck0_in};
    end

    dma_req_sense u_dma_req0_n (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .req_pin_n (sel_dma_req0_n ? pin_ck0_in : 1'b1),
        .edge_mode (ctrl_r[`CTRL_DREQ_EDGE0]),
        .consume   (ack_r && is_dma),
        .pending   (dreq_pend[0])
    );
    dma_req_sense u_dma_req1_n (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .req_pin_n (dma_req1_n),
        .edge_mode (ctrl_r[`CTRL_DREQ_EDGE1]),
        .consume   (ack_r && is_dma),
        .pending   (dreq_pend[1])
    );

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx0_r      <= 1'b1;
            tx1_r      <= 1'b1;
            txc_prev_r <= 2'b00;
        end else begin
            // Previous level resets low so a clock already low gives no false fall
            txc_prev_r <= {async_tx_clk1, async_tx_clk0};
            if (txc_prev_r[0] && !async_tx_clk0)
                tx0_r <= async_tx_bit0;
            if (txc_prev_r[1] && !async_tx_clk1)
                tx1_r <= async_tx_bit1;
        end
    end
    assign async_tx0 = tx0_r;
    assign async_tx1 = tx1_r;

    // --------------------------------------------------------------
    // Avalon slave, zero wait
    // --------------------------------------------------------------
    assign avs_waitrequest = 1'b0;
    always @* begin
        case (avs_address)
        `REG_CTRL:   avs_readdata = {24'h000000, ctrl_r};
        // Pending interrupts: irq priority via software view
        `REG_STATUS: avs_readdata = {20'h00000, dreq_pend, !sync_c_r[4], !sync_c_r[3],
                                     !sync_c_r[2] && !breq, nmi_pend_r, busy_r,
                                     state_r == ST_GRANT, 1'b0, state_r};
        `REG_CYCLE:  avs_readdata = {23'h000000, first_r, 2'b00, cls_r, 1'b0, cyc_r};
        `REG_ADDR:   avs_readdata = {12'h000, nmi_pend_r ? `NMI_VECTOR : pc_r};
        `REG_WDATA:  avs_readdata = {24'h000000, wdata_r};
        `REG_RDATA:  avs_readdata = {24'h000000, rdata_r};
        `REG_DMA:    avs_readdata = {30'h00000000, dma_last_r};
        default:     avs_readdata = `UNMAPPED_DATA;
        endcase
    end
endmodule

// file: tb/bus_pins_chk.sv
`timescale 1ns/1ps
module bus_pins_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Drive enables
    input wire logic addr_oe,
    input wire logic data_oe,
    input wire logic ctrl_oe,
    // Strobes and status
    input wire logic memory_strobe_n,
    input wire logic io_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic opcode_cycle_n,
    input wire logic refresh_cycle_n,
    input wire logic halt_n,
    input wire logic cycle_status,
    input wire logic system_clock_out,
    // Bus exchange and serial
    input wire logic ext_bus_request_n,
    input wire logic ext_bus_grant_n,
    input wire logic async_tx0,
    input wire logic async_tx_clk0
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // Bus exchange
    // ----------------------------------------
    AST_GRANT_FLOAT: assert property (
        !ext_bus_grant_n |-> !addr_oe && !data_oe && !ctrl_oe)
        else $error("grant shown while bus still driven");
    // Bound covers a T1 T2 T3 cycle with a few wait states
    AST_REQ_TAKEN: assert property ($fell(ext_bus_request_n) |-> ##[1:80]
        (!ext_bus_grant_n || ext_bus_request_n)) else $error("bus request not honoured");
    AST_GRANT_DROP: assert property (ext_bus_request_n && !ext_bus_grant_n |-> ##[1:8]
        ext_bus_grant_n) else $error("grant held after request removed");
    // ----------------------------------------
    // Strobes and status
    // ----------------------------------------
    AST_STROBE_EXCL: assert property (!(!memory_strobe_n && !io_strobe_n))
        else $error("memory and io strobes together");
    AST_REFRESH_NORW: assert property (
        !refresh_cycle_n |-> read_strobe_n && write_strobe_n)
        else $error("refresh cycle with read or write strobe");
    AST_READ_FLOAT: assert property (!read_strobe_n |-> !data_oe)
        else $error("data driven during read");
    AST_WRITE_DRIVE: assert property (!write_strobe_n |-> data_oe && addr_oe)
        else $error("write strobe without driven bus");
    AST_HALT_CODE: assert property (!halt_n |-> cycle_status == opcode_cycle_n)
        else $error("halt status code wrong");
    // The divider first moves one edge after reset release
    AST_CLK_HALF: assert property (
        $past(reset_n) |-> system_clock_out != $past(system_clock_out))
        else $error("system clock not at half rate");
    AST_TX_FALL: assert property (
        $changed(async_tx0) |-> !$past(async_tx_clk0) && $past(async_tx_clk0, 2))
        else $error("transmit data changed away from tx clock fall");
    COV_GRANT: cover property (!ext_bus_grant_n);
    COV_REFRESH: cover property (!refresh_cycle_n && !memory_strobe_n);
    COV_HALT: cover property (!halt_n);
endmodule
bind bus_pins bus_pins_chk u_chk (.sys_clk, .reset_n, .addr_oe, .data_oe, .ctrl_oe,
    .memory_strobe_n, .io_strobe_n, .read_strobe_n, .write_strobe_n, .opcode_cycle_n,
    .refresh_cycle_n, .halt_n, .cycle_status, .system_clock_out, .ext_bus_request_n,
    .ext_bus_grant_n, .async_tx0, .async_tx_clk0);

// file: tb/bus_far_model.sv
`timescale 1ns/1ps
module bus_far_model (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // From the device, and slow from the test
    input wire logic [19:0] addr_out,
    input wire logic [7:0]  data_out,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [3:0]  slow,
    // To the device, and last_addr to the test
    output logic     [7:0]  data_in,
    output logic            wait_n,
    output logic     [19:0] last_addr
);
    logic [7:0] mem [0:255];
    logic [7:0] churn;
    logic [3:0] cnt;
    // drive only on read; released bus churns so no stale value shows
    assign data_in = !read_strobe_n ? mem[addr_out[7:0]] : churn;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            churn <= 8'h5A;
            cnt <= 4'h0;
            wait_n <= 1'h1;
        end else begin
            churn <= churn + 8'h6B;
            // slow device holds wait low until ready
            cnt <= (read_strobe_n && write_strobe_n) ? 4'h0 : cnt + 4'h1;
            wait_n <= (read_strobe_n && write_strobe_n) || (cnt >= slow);
            if (!write_strobe_n) begin
                mem[addr_out[7:0]] <= data_out;
                last_addr <= addr_out;
            end
        end
    end
endmodule

// file: tb/cpu_external_bus_status_test.sv
`timescale 1ns/1ps
`include "bus_pins_regs.vh"
module cpu_external_bus_status_test;
    logic sys_clk, reset_n, avs_read, avs_write, ext_bus_request_n, nmi_n;
    logic [3:0] avs_address, slow;
    logic [31:0] avs_writedata, q;
    logic [7:0] pc;
    logic [5:0] snap;
    logic [19:0] last_addr;
    int num_errors, tests_run;
    wire [31:0] avs_readdata;
    wire [19:0] addr_out;
    wire [7:0] data_in, data_out;
    wire avs_waitrequest, addr_oe, data_oe, memory_strobe_n, io_strobe_n, read_strobe_n;
    wire write_strobe_n, ctrl_oe, opcode_cycle_n, refresh_cycle_n, halt_n, cycle_status;
    wire system_clock_out, ext_bus_grant_n, wait_n, pin_ck0_out, pin_ck0_oe, pin_ck1_out;
    wire pin_ck1_oe, dma_done1_n, async_tx0, async_tx1, async_clock0_in, async_clock1_in;
    wire sync_serial_rx, clear_to_send1_n;
    wire irq0_n = 1'h1, irq1_n = 1'h1, irq2_n = 1'h1, dma_req1_n = 1'h1;
    // Free-running peripheral sources keep the pin muxes exercised
    wire timer1_pulse_out = pc[6], async_clock0_out = pc[1], async_clock0_oe = pc[2];
    wire async_clock1_out = pc[3], async_clock1_oe = pc[4], async_tx_clk0 = pc[3];
    wire async_tx_clk1 = pc[4], async_tx_bit0 = pc[5], async_tx_bit1 = pc[7];
    wire pin_ck0_in = pc[0], pin_ck1_in = pc[5], pin_rxs_clear_to_send1_n = pc[2];
    bus_pins u_dut (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .addr_out, .addr_oe, .data_in, .data_out, .data_oe,
        .memory_strobe_n, .io_strobe_n, .read_strobe_n, .write_strobe_n, .ctrl_oe,
        .opcode_cycle_n, .refresh_cycle_n, .halt_n, .cycle_status, .system_clock_out,
        .ext_bus_request_n, .ext_bus_grant_n, .wait_n, .nmi_n, .irq0_n, .irq1_n, .irq2_n,
        .timer1_pulse_out, .async_clock0_out, .async_clock0_oe, .async_clock1_out,
        .async_clock1_oe, .async_tx_clk0, .async_tx_clk1, .async_tx_bit0, .async_tx_bit1,
        .pin_ck0_in, .pin_ck0_out, .pin_ck0_oe, .pin_ck1_in, .pin_ck1_out, .pin_ck1_oe,
        .pin_rxs_clear_to_send1_n, .dma_req1_n, .dma_done1_n, .async_tx0, .async_tx1, .async_clock0_in,
        .async_clock1_in, .sync_serial_rx, .clear_to_send1_n);
    bus_far_model u_far (.sys_clk, .reset_n, .addr_out, .data_out, .read_strobe_n,
        .write_strobe_n, .slow, .data_in, .wait_n, .last_addr);
    // ----------------------------------------
    // Clock, sources and helpers
    // ----------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        pc <= pc + 8'h01;
        if (!memory_strobe_n || !io_strobe_n)
            snap <= {cycle_status, halt_n, opcode_cycle_n, memory_strobe_n, io_strobe_n,
                refresh_cycle_n};
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            avs(1'h0, `REG_STATUS, 32'h0);
            n++;
        end while (q[5] !== 1'h0 && n < 100);
    endtask
    task automatic run_cyc(input logic [8:0] cmd, input logic [19:0] a, input logic [7:0] d);
        snap <= 6'h3F;
        avs(1'h1, `REG_ADDR, {12'h000, a});
        avs(1'h1, `REG_WDATA, {24'h000000, d});
        avs(1'h1, `REG_CYCLE, {23'h000000, cmd});
        wait_idle();
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_mem;
        for (int s = 0; s < 2; s++) begin
            slow <= s ? 4'h5 : 4'h0;
            run_cyc({6'h00, `CYC_MEM_WR}, 20'hFA5C3 + s, 8'h3C + s);
            check("write address", last_addr, 20'hFA5C3 + s);
            run_cyc({6'h00, `CYC_MEM_RD}, 20'hFA5C3 + s, 8'h00);
            avs(1'h0, `REG_RDATA, 32'h0);
            check("read data", q[7:0], 8'h3C + s);
        end
    endtask
    task automatic t_status;
        logic [8:0] cm [0:7];
        logic [5:0] ex [0:7];
        logic [5:0] mk [0:7];
        cm = '{9'h100, 9'h000, 9'h001, 9'h004, 9'h011, 9'h023, 9'h033, 9'h005};
        ex = '{6'h13, 6'h33, 6'h3B, 6'h3D, 6'h0B, 6'h05, 6'h0F, 6'h02};
        mk = '{6'h3F, 6'h3F, 6'h3F, 6'h3F, 6'h2F, 6'h0F, 6'h0F, 6'h07};
        foreach (cm[i]) begin
            run_cyc(cm[i], 20'h00042, 8'h00);
            check("cycle status", snap & mk[i], ex[i]);
        end
    endtask
    task automatic t_halt;
        for (int s = 0; s < 2; s++) begin
            avs(1'h1, `REG_CYCLE, s ? {29'h0, `CYC_SLEEP} : {29'h0, `CYC_HALT});
            repeat (12) @(posedge sys_clk);
            check("halt code", {cycle_status, halt_n, opcode_cycle_n}, s ? 3'h5 : 3'h0);
            nmi_n <= 1'h0;
            for (int n = 0; n < 60 && halt_n !== 1'h1; n++) @(posedge sys_clk);
            check("halt released", halt_n, 1'h1);
            avs(1'h0, `REG_ADDR, 32'h0);
            check("nmi vector", q[19:0], `NMI_VECTOR);
            nmi_n <= 1'h1;
            wait_idle();
        end
    endtask
    task automatic t_exchange;
        slow <= 4'h6;
        avs(1'h1, `REG_CYCLE, {29'h0, `CYC_MEM_RD});
        ext_bus_request_n <= 1'h0;
        for (int n = 0; n < 100 && ext_bus_grant_n !== 1'h0; n++) @(posedge sys_clk);
        repeat (6) @(posedge sys_clk);
        check("granted floats", {ext_bus_grant_n, addr_oe, data_oe, ctrl_oe}, 4'h0);
        ext_bus_request_n <= 1'h1;
        for (int n = 0; n < 20 && ext_bus_grant_n !== 1'h1; n++) @(posedge sys_clk);
        wait_idle();
        check("resumed", {ext_bus_grant_n, q[5]}, 2'h2);
    endtask
    task automatic t_pins;
        for (int b = 0; b < 6; b++) begin
            avs(1'h1, `REG_CTRL, 32'h1 << b);
            repeat (2) @(negedge sys_clk);
            if (b < 2) check("timer on a18", addr_out[18], timer1_pulse_out);
            else if (b < 4) check("ck0 as request", pin_ck0_oe, 1'h0);
            else if (b == 4) check("ck1 as done", {pin_ck1_oe, pin_ck1_out}, 2'h3);
            else check("clear_to_send1_n routed", clear_to_send1_n, pin_rxs_clear_to_send1_n);
        end
        avs(1'h1, `REG_CTRL, 32'h0);
        @(negedge sys_clk);
        check("ck1 default", pin_ck1_out, async_clock1_out);
        check("rxs default", sync_serial_rx, pin_rxs_clear_to_send1_n);
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        {reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {ext_bus_request_n, nmi_n, slow, pc, snap} = {2'h3, 4'h0, 8'h00, 6'h3F};
        repeat (4) @(posedge sys_clk);
        check("reset float", {addr_oe, data_oe, ctrl_oe}, 3'h0);
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'h1;
        repeat (4) @(posedge sys_clk);
        t_mem();
        t_status();
        t_halt();
        t_exchange();
        t_pins();
        close_out();
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        close_out();
    end
endmodule
